// ===== rtl/csfw_pkg.sv
// Summary of operation
// (RULE_01) Carry set on add carry or subtract borrow
// (RULE_02) Half carry set on nibble carry or borrow
// (RULE_03) Two user flags, written by software only
// (RULE_04) Bank select picks one of four banks
// (RULE_05) Overflow set on carry, borrow, multiply/divide overflow
// (RULE_06) Parity flag is odd parity of accumulator
// (RULE_07) Status word at D0h, reset zero
// (RULE_08) Accumulator at E0h, operand at F0h
// (RULE_09) Parity tracks accumulator; writes update same cycle (code: a same-cycle op wins over writes to carry, half, overflow)
package csfw_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] CSFW_STATUS_ADDR = 8'hD0;
	localparam logic [7:0] CSFW_MAIN_ADDR = 8'hE0;
	localparam logic [7:0] CSFW_SECOND_ADDR = 8'hF0;
	localparam logic [7:0] CSFW_RESET_VAL = 8'h00;

	// ----------------------------------------
	// Status word fields
	// ----------------------------------------
	localparam int CSFW_CARRY_BIT = 7;
	localparam int CSFW_HALF_BIT = 6;
	localparam int CSFW_UF0_BIT = 5;
	localparam int CSFW_BSH_BIT = 4;
	localparam int CSFW_BSL_BIT = 3;
	localparam int CSFW_OVF_BIT = 2;
	localparam int CSFW_UF1_BIT = 1;
	localparam int CSFW_PAR_BIT = 0;

	// ----------------------------------------
	// Working register bank size
	// ----------------------------------------
	localparam logic [7:0] CSFW_BANK_SIZE = 8'h08;

	// ----------------------------------------
	// Arithmetic operation kinds
	// ----------------------------------------
	typedef enum logic [3:0] {
		CSFW_OP_ADD = 4'h1,
		CSFW_OP_SUB = 4'h2,
		CSFW_OP_MUL = 4'h4,
		CSFW_OP_DIV = 4'h8
	} csfw_op_type;

endpackage

// ===== rtl/csfw_parity.sv
`timescale 1ns/1ps
module csfw_parity
	import csfw_pkg::*;
(
	input wire logic [7:0] data_i,
	output logic odd_o
);
	// Modulo-2 sum of all eight bits
	assign odd_o = ^data_i; // RULE_06
endmodule

// ===== rtl/csfw_status_word.sv
`timescale 1ns/1ps
module csfw_status_word
	import csfw_pkg::*;
(
	input wire logic mclk_i,
	input wire logic srst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Datapath flag update
	input wire logic arith_valid_i,
	input wire logic [3:0] arith_op_i,
	input wire logic arith_carry_i,
	input wire logic arith_half_i,
	input wire logic arith_ovf_i,
	// Datapath accumulator and operand load
	input wire logic main_load_i,
	input wire logic [7:0] main_data_i,
	input wire logic second_load_i,
	input wire logic [7:0] second_data_i,
	// State to core
	output logic [7:0] status_word_o,
	output logic [7:0] main_operand_o,
	output logic [7:0] secondary_operand_o,
	output logic [7:0] bank_base_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic carry_flag;
	logic half_carry_flag;
	logic user_flag_zero;
	logic user_flag_one;
	logic bank_select_high;
	logic bank_select_low;
	logic arith_excess_flag;
	logic [7:0] main_operand_reg;
	logic [7:0] secondary_operand_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic status_wr;
	logic main_wr;
	logic second_wr;
	logic is_add;
	logic is_sub;
	logic is_muldiv;
	logic [7:0] next_main;
	logic odd_sum_flag;
	logic [7:0] status_word_reg;
	logic [7:0] next_rdata;
	logic [1:0] bank_sel;
	logic flag_op;
	logic next_carry;
	logic next_half;
	logic next_excess;
	logic next_user_zero;
	logic next_user_one;
	logic next_bank_high;
	logic next_bank_low;
	logic [7:0] next_second;
	logic [7:0] next_read;
	logic [7:0] next_bank_base;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// True when the register port addresses the given location
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] loc);
		return addr == loc;
	endfunction

	// Byte offset of a working register bank, four banks of eight bytes
	function automatic logic [7:0] bank_offset(input logic [1:0] sel);
		return 8'(sel * CSFW_BANK_SIZE);
	endfunction

	// Address decode of writes
	assign status_wr = reg_wr_i && addr_hit(reg_addr_i, CSFW_STATUS_ADDR); // RULE_07
	assign main_wr = reg_wr_i && addr_hit(reg_addr_i, CSFW_MAIN_ADDR); // RULE_08
	assign second_wr = reg_wr_i && addr_hit(reg_addr_i, CSFW_SECOND_ADDR); // RULE_08

	// Operation classes
	assign is_add = arith_valid_i && (arith_op_i == CSFW_OP_ADD);
	assign is_sub = arith_valid_i && (arith_op_i == CSFW_OP_SUB);
	assign is_muldiv = arith_valid_i &&
		((arith_op_i == CSFW_OP_MUL) || (arith_op_i == CSFW_OP_DIV));

	// Accumulator next value, software write wins over datapath load
	assign next_main = main_wr ? reg_wdata_i : (main_load_i ? main_data_i : main_operand_reg);

	// Parity from the stored accumulator, live every cycle
	csfw_parity u_parity (
		.data_i(main_operand_reg),
		.odd_o(odd_sum_flag)
	); // RULE_09

	// Assembled status word
	assign status_word_reg = {carry_flag, half_carry_flag, user_flag_zero,
		bank_select_high, bank_select_low, arith_excess_flag,
		user_flag_one, odd_sum_flag}; // RULE_07

	// Read mux, unmapped addresses read zero
	assign next_rdata = addr_hit(reg_addr_i, CSFW_STATUS_ADDR) ? status_word_reg :
		addr_hit(reg_addr_i, CSFW_MAIN_ADDR) ? main_operand_reg :
		addr_hit(reg_addr_i, CSFW_SECOND_ADDR) ? secondary_operand_reg : CSFW_RESET_VAL;

	// Bank select pair and the base of the bank it picks
	assign bank_sel = {bank_select_high, bank_select_low};
	assign next_bank_base = bank_offset(bank_sel); // RULE_04

	// ----------------------------------------
	// Next flag values
	// ----------------------------------------
	// Add and subtract report their own carry and nibble carry
	assign flag_op = is_add || is_sub;

	// Datapath result wins over a same-cycle software write
	// Multiply and divide clear both carries and report overflow
	assign next_carry = flag_op ? arith_carry_i :
		is_muldiv ? 1'h0 :
		status_wr ? reg_wdata_i[CSFW_CARRY_BIT] : carry_flag; // RULE_01 RULE_09
	assign next_half = flag_op ? arith_half_i :
		is_muldiv ? 1'h0 :
		status_wr ? reg_wdata_i[CSFW_HALF_BIT] : half_carry_flag; // RULE_02 RULE_09
	assign next_excess = flag_op ? arith_carry_i :
		is_muldiv ? arith_ovf_i :
		status_wr ? reg_wdata_i[CSFW_OVF_BIT] : arith_excess_flag; // RULE_05 RULE_09

	// Software-only bits, never touched by the datapath
	assign next_user_zero = status_wr ? reg_wdata_i[CSFW_UF0_BIT] :
		user_flag_zero; // RULE_03
	assign next_user_one = status_wr ? reg_wdata_i[CSFW_UF1_BIT] :
		user_flag_one; // RULE_03
	assign next_bank_high = status_wr ? reg_wdata_i[CSFW_BSH_BIT] :
		bank_select_high; // RULE_04
	assign next_bank_low = status_wr ? reg_wdata_i[CSFW_BSL_BIT] :
		bank_select_low; // RULE_04

	// ----------------------------------------
	// Operand next values
	// ----------------------------------------
	// Secondary operand, software write wins over datapath load
	assign next_second = second_wr ? reg_wdata_i :
		(second_load_i ? second_data_i : secondary_operand_reg); // RULE_08

	// Read return, idle at zero outside the answer cycle
	assign next_read = reg_rd_i ? next_rdata : CSFW_RESET_VAL;

	// ----------------------------------------
	// Arithmetic flags
	// ----------------------------------------
	// Result flags, cleared by reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			carry_flag <= 1'h0;
			half_carry_flag <= 1'h0;
			arith_excess_flag <= 1'h0;
		end else begin
			carry_flag <= next_carry;
			half_carry_flag <= next_half;
			arith_excess_flag <= next_excess;
		end
	end

	// ----------------------------------------
	// Software-only bits
	// ----------------------------------------
	// User flags and bank select
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			user_flag_zero <= 1'h0;
			user_flag_one <= 1'h0;
			bank_select_high <= 1'h0;
			bank_select_low <= 1'h0;
		end else begin
			user_flag_zero <= next_user_zero;
			user_flag_one <= next_user_one;
			bank_select_high <= next_bank_high;
			bank_select_low <= next_bank_low;
		end
	end

	// ----------------------------------------
	// Operand registers
	// ----------------------------------------
	// Accumulator and secondary operand
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			main_operand_reg <= CSFW_RESET_VAL; // RULE_08
			secondary_operand_reg <= CSFW_RESET_VAL; // RULE_08
		end else begin
			main_operand_reg <= next_main;
			secondary_operand_reg <= next_second;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Mirrors of the internal state, all one cycle behind it
	// Parity and the other status bits are registered together
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			reg_rdata_o <= CSFW_RESET_VAL;
			status_word_o <= CSFW_RESET_VAL;
			main_operand_o <= CSFW_RESET_VAL;
			secondary_operand_o <= CSFW_RESET_VAL;
			bank_base_o <= CSFW_RESET_VAL;
		end else begin
			reg_rdata_o <= next_read;
			status_word_o <= status_word_reg;
			main_operand_o <= main_operand_reg;
			secondary_operand_o <= secondary_operand_reg;
			bank_base_o <= next_bank_base; // RULE_04
		end
	end

endmodule

// ===== dv/csfw_checker.sv
`timescale 1ns/1ps
module csfw_checker
	import csfw_pkg::*;
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic arith_valid_i,
	input wire logic [3:0] arith_op_i,
	input wire logic arith_carry_i,
	input wire logic arith_half_i,
	input wire logic arith_ovf_i,
	input wire logic [7:0] status_word_o,
	input wire logic [7:0] main_operand_o,
	input wire logic [7:0] bank_base_o
);
	// Decoded events
	wire sw = reg_wr_i && reg_addr_i == CSFW_STATUS_ADDR;
	wire add_sub = arith_valid_i && arith_op_i inside {4'h1, 4'h2};
	wire mul_div = arith_valid_i && arith_op_i inside {4'h4, 4'h8};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	carry_flag_a: assert property (
		add_sub |-> ##2 status_word_o[7] == $past(arith_carry_i, 2) && status_word_o[2] == status_word_o[7]
	) else $error("carry wrong");
	half_carry_a: assert property (
		add_sub |-> ##2 status_word_o[6] == $past(arith_half_i, 2)
	) else $error("half carry wrong");
	mul_div_a: assert property (
		mul_div |-> ##2 status_word_o[7:6] == 2'h0 && status_word_o[2] == $past(arith_ovf_i, 2)
	) else $error("overflow wrong");
	parity_track_a: assert property (status_word_o[0] == ^main_operand_o)
		else $error("parity wrong");
	bank_base_a: assert property (bank_base_o == {3'h0, status_word_o[4:3], 3'h0})
		else $error("bank base wrong");
	sw_write_a: assert property (
		sw |-> ##2 {status_word_o[5:3], status_word_o[1]} == $past({reg_wdata_i[5:3], reg_wdata_i[1]}, 2)
	) else $error("status write lost");
	user_hold_a: assert property (
		!$past(sw, 2) |-> $stable({status_word_o[5:3], status_word_o[1]})
	) else $error("user bits moved");
	read_status_a: assert property (
		reg_rd_i && reg_addr_i == CSFW_STATUS_ADDR |=> reg_rdata_o == status_word_o
	) else $error("status read wrong");
endmodule

bind csfw_status_word csfw_checker i_csfw_checker (.*);

// ===== dv/csfw_dp_model.sv
`timescale 1ns/1ps
module csfw_dp_model (
	input wire logic mclk_i,
	output logic valid_o = 1'h0,
	output logic [3:0] op_o = 4'h0,
	output logic [2:0] flags_o = 3'h0,
	output logic [1:0] load_o = 2'h0,
	output logic [7:0] data_o = 8'h00
);
	// One op (no load) or one load; released lines are scrambled
	task automatic send(input logic [3:0] o, input logic [2:0] f, input logic [1:0] l,
		input logic [7:0] d);
		@(posedge mclk_i);
		valid_o <= l == 2'h0;
		op_o <= o;
		flags_o <= f;
		load_o <= l;
		data_o <= d;
		@(posedge mclk_i);
		valid_o <= 1'h0;
		load_o <= 2'h0;
		flags_o <= ~f;
		data_o <= ~d;
	endtask
endmodule

// ===== dv/csfw_status_word_tb.sv
`timescale 1ns/1ps
module csfw_status_word_tb
	import csfw_pkg::*;
;
	logic mclk_i = 1'h0;
	logic srst_i = 1'h1;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	wire logic arith_valid_i, arith_carry_i, arith_half_i, arith_ovf_i, main_load_i, second_load_i;
	wire logic [3:0] arith_op_i;
	wire logic [7:0] main_data_i, reg_rdata_o, status_word_o, main_operand_o, secondary_operand_o;
	wire logic [7:0] bank_base_o;
	wire logic [7:0] second_data_i = main_data_i;
	int n_fail = 0;
	int samples_checked = 0;
	int seed = 32'hF057;
	logic [7:0] ps = 8'h00;
	logic [7:0] exp_main = 8'h00;
	logic [7:0] d;
	logic [7:0] r;
	logic [3:0] ops [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

	csfw_status_word i_csfw_status_word (.*);
	csfw_dp_model i_csfw_dp_model (.mclk_i(mclk_i), .valid_o(arith_valid_i), .op_o(arith_op_i),
		.flags_o({arith_carry_i, arith_half_i, arith_ovf_i}),
		.load_o({second_load_i, main_load_i}), .data_o(main_data_i));

	// Clock and watchdog
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end

	// Expected flags after one op
	function automatic logic [7:0] xf(input logic [7:0] p, input logic [3:0] o, input logic [2:0] f);
		logic [7:0] q;
		q = p;
		q[7] = o < 4'h4 ? f[2] : 1'h0;
		q[6] = o < 4'h4 ? f[1] : 1'h0;
		q[2] = o < 4'h4 ? f[2] : f[0];
		return q;
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge mclk_i);
		reg_wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'h0;
		#1 chk("rdata", e, reg_rdata_o);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'h0;
		rd(CSFW_STATUS_ADDR, 8'h00);
		rd(CSFW_MAIN_ADDR, 8'h00);
		rd(CSFW_SECOND_ADDR, 8'h00);
		rd(8'hD1, 8'h00);
		repeat (80) begin
			r = $random(seed);
			d = $random(seed);
			if (r[1:0] == 2'h0) begin
				wr(CSFW_STATUS_ADDR, d);
				ps = {d[7:1], 1'h0};
			end else if (r[1:0] == 2'h3) begin
				i_csfw_dp_model.send(ops[r[3:2]], r[6:4], 2'h0, 8'h00);
				ps = xf(ps, ops[r[3:2]], r[6:4]);
			end else begin
				if (r[0])
					wr(CSFW_MAIN_ADDR, d);
				else
					i_csfw_dp_model.send(4'h0, 3'h0, 2'h1, d);
				exp_main = d;
			end
			ps[0] = ^exp_main;
			rd(CSFW_STATUS_ADDR, ps);
			rd(CSFW_MAIN_ADDR, exp_main);
			chk("bank", {3'h0, ps[4:3], 3'h0}, bank_base_o);
			chk("main_out", exp_main, main_operand_o);
		end
		fork
			wr(CSFW_STATUS_ADDR, 8'hFF);
			i_csfw_dp_model.send(CSFW_OP_MUL, 3'h0, 2'h0, 8'h00);
		join
		ps = {7'h1D, ^exp_main};
		rd(CSFW_STATUS_ADDR, ps);
		i_csfw_dp_model.send(4'h3, 3'h7, 2'h0, 8'h00);
		rd(CSFW_STATUS_ADDR, ps);
		wr(CSFW_SECOND_ADDR, 8'hC3);
		rd(CSFW_SECOND_ADDR, 8'hC3);
		i_csfw_dp_model.send(4'h0, 3'h0, 2'h2, 8'h5A);
		rd(CSFW_SECOND_ADDR, 8'h5A);
		chk("second_out", 8'h5A, secondary_operand_o);
		fork
			wr(CSFW_MAIN_ADDR, 8'hA5);
			i_csfw_dp_model.send(4'h0, 3'h0, 2'h1, 8'h3C);
		join
		rd(CSFW_MAIN_ADDR, 8'hA5);
		stop_test();
	end
endmodule
